// >>> rtl/cgr_bit_timer.sv
// Bit timing engine: quantum prescaler, segments, resync, sampling
`timescale 1ns/1ps
`include "cgr_regs.svh"
module cgr_bit_timer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire cgr_pkg::cgr_timing_s cfg,
  input wire logic enable,
  input wire logic rx_in,
  output logic sample_pulse,
  output logic sample_bit
);
  import cgr_pkg::*;

  typedef struct packed {
    logic [5:0] tq_cnt;
    cgr_seg_e seg;
    logic [3:0] q_cnt;
    logic [3:0] seg_len;
    logic [2:0] hist;
    logic rx_prev;
    logic sync_done;
    logic pulse;
    logic bit_val;
  } cgr_bt_s;

  cgr_bt_s s_q;
  cgr_bt_s s_d;

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

  logic tq_tick;
  logic last_clk;
  logic edge_seen;
  logic [3:0] sjw;
  logic [3:0] ph2_len;

  always_comb
  begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    tq_tick = (s_q.tq_cnt == cfg.baud_prescale);
    last_clk = tq_tick && (s_q.q_cnt + 4'h1 == s_q.seg_len);
    sjw = {2'b00, cfg.resync_jump_width} + 4'h1;
    ph2_len = {1'b0, cfg.phase_segment_two} + 4'h1;
    edge_seen = enable && s_q.rx_prev && !rx_in && !s_q.sync_done;
    s_d.rx_prev = rx_in;
    s_d.hist = {s_q.hist[1:0], rx_in};
    s_d.tq_cnt = tq_tick ? 6'h00 : s_q.tq_cnt + 6'h01;
    if (tq_tick)
      s_d.q_cnt = s_q.q_cnt + 4'h1;
    if (!enable)
    begin
      s_d.seg = CGR_SEG_SYNC;
      s_d.q_cnt = 4'h0;
      s_d.seg_len = 4'h1;
      s_d.sync_done = 1'b0;
    end
    // Edge on a segment's last clock is left to the boundary, or the count overshoots
    else if (edge_seen && !last_clk && (s_q.seg == CGR_SEG_PROP || s_q.seg == CGR_SEG_PH1))
    begin
      // Late edge: in phase one, lengthen it by the full jump width; in propagation, only mark the resync done
      s_d.sync_done = 1'b1;
      if (s_q.seg == CGR_SEG_PH1)
        s_d.seg_len = s_q.seg_len + sjw;
    end
    else if (edge_seen && s_q.seg == CGR_SEG_PH2)
    begin
      // Early edge: end phase two at once if no more than the jump width of it is left; otherwise only mark the resync done
      s_d.sync_done = 1'b1;
      if (ph2_len - s_q.q_cnt <= sjw)
      begin
        s_d.seg = CGR_SEG_SYNC;
        s_d.q_cnt = 4'h0;
        s_d.seg_len = 4'h1;
        s_d.tq_cnt = 6'h00;
      end
    end
    else if (last_clk)
    begin
      s_d.q_cnt = 4'h0;
      case (s_q.seg)
        CGR_SEG_SYNC:
        begin
          s_d.seg = CGR_SEG_PROP;
          s_d.seg_len = {1'b0, cfg.propagation_segment} + 4'h1;
          s_d.sync_done = 1'b0;
        end
        CGR_SEG_PROP:
        begin
          s_d.seg = CGR_SEG_PH1;
          s_d.seg_len = {1'b0, cfg.phase_segment_one} + 4'h1;
        end
        CGR_SEG_PH1:
        begin
          // Sample point at end of phase one
          s_d.seg = CGR_SEG_PH2;
          s_d.seg_len = ph2_len;
          s_d.pulse = 1'b1;
          s_d.bit_val = cfg.triple_sampling ? maj3({s_q.hist[1:0], rx_in}) : rx_in;
        end
        CGR_SEG_PH2:
        begin
          s_d.seg = CGR_SEG_SYNC;
          s_d.seg_len = 4'h1;
        end
        default:
        begin
          s_d.seg = CGR_SEG_SYNC;
          s_d.seg_len = 4'h1;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.seg_len <= 4'h1;
      s_q.rx_prev <= 1'b1;
      s_q.bit_val <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign sample_pulse = s_q.pulse;
  assign sample_bit = s_q.bit_val;
endmodule // cgr_bit_timer

// >>> rtl/cgr_can_timer.sv
// Prescaled free-running CAN timer with overrun event
`timescale 1ns/1ps
`include "cgr_regs.svh"
module cgr_can_timer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic [7:0] prescale,
  output logic [15:0] count,
  output logic wrap
);
  import cgr_pkg::*;

  typedef struct packed {
    logic [2:0] div8;
    logic [7:0] pre;
    logic [15:0] cnt;
    logic wrap;
  } cgr_tm_s;

  cgr_tm_s s_q;
  cgr_tm_s s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.wrap = 1'b0;
    if (enable)
    begin
      s_d.div8 = s_q.div8 + 3'h1;
      if (s_q.div8 == `CGR_TIM_PRE_DIV)
      begin
        s_d.pre = s_q.pre + 8'h01;
        if (s_q.pre >= prescale)
        begin
          s_d.pre = 8'h00;
          s_d.cnt = s_q.cnt + 16'h0001;
          s_d.wrap = (s_q.cnt == 16'hffff);
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign count = s_q.cnt;
  assign wrap = s_q.wrap;
endmodule // cgr_can_timer

// >>> rtl/cgr_pkg.sv
// Types shared by the CAN general register block
package cgr_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } cgr_wreq_s;
  typedef struct packed {
    logic [5:0] baud_prescale;
    logic [1:0] resync_jump_width;
    logic [2:0] propagation_segment;
    logic [2:0] phase_segment_one;
    logic [2:0] phase_segment_two;
    logic triple_sampling;
  } cgr_timing_s;
  typedef enum logic [1:0] {
    CGR_SEG_SYNC = 2'b00,
    CGR_SEG_PROP = 2'b01,
    CGR_SEG_PH1 = 2'b11,
    CGR_SEG_PH2 = 2'b10
  } cgr_seg_e;
endpackage

// >>> rtl/cgr_regs.svh
// Register offsets, field positions and reset values of the CAN general register block
`ifndef CGR_REGS_SVH
`define CGR_REGS_SVH
`define CGR_OFF_IE_LO 8'h00
`define CGR_OFF_IE_HI 8'h04
`define CGR_OFF_SIT_LO 8'h08
`define CGR_OFF_SIT_HI 8'h0c
`define CGR_OFF_BT1 8'h10
`define CGR_OFF_BT2 8'h14
`define CGR_OFF_BT3 8'h18
`define CGR_OFF_TCON 8'h1c
`define CGR_OFF_TIM_LO 8'h20
`define CGR_OFF_TIM_HI 8'h24
`define CGR_OFF_TTC_LO 8'h28
`define CGR_OFF_TTC_HI 8'h2c
`define CGR_OFF_TEC 8'h30
`define CGR_OFF_GSTAT 8'h34
`define CGR_OFF_CTRL 8'h38
`define CGR_BRP_LSB 1
`define CGR_BRP_MSB 6
`define CGR_SJW_LSB 5
`define CGR_SJW_MSB 6
`define CGR_PRS_LSB 1
`define CGR_PRS_MSB 3
`define CGR_PHS2_LSB 4
`define CGR_PHS2_MSB 6
`define CGR_PHS1_LSB 1
`define CGR_PHS1_MSB 3
`define CGR_SMP_BIT 0
`define CGR_BT1_MASK 8'h7e
`define CGR_BT2_MASK 8'h6e
`define CGR_BT3_MASK 8'h7f
`define CGR_IE_HI_MASK 8'h7f
`define CGR_RST_BYTE 8'h00
`define CGR_TIM_PRE_DIV 3'h7
`define CGR_HP_NONE 4'hf
`define CGR_RESP_OKAY 2'b00
`define CGR_RESP_SLVERR 2'b10
`endif

// >>> rtl/cgr_top.sv
// CAN general registers: interrupt enables/status, bit timing, timers, error count
`timescale 1ns/1ps
`include "cgr_regs.svh"
module cgr_top
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [14:0] object_event,
  input wire logic [14:0] object_ack,
  input wire logic [7:0] transmit_error_count,
  input wire logic trigger_capture,
  input wire logic rx_in,
  output logic [14:0] object_irq_status,
  output logic [3:0] highest_priority_object,
  output logic timer_overrun_flag,
  output logic sample_pulse,
  output logic sample_bit
);
  import cgr_pkg::*;

  typedef struct packed {
    logic aw_full;
    cgr_wreq_s wr;
    logic w_full;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [14:0] ie;
    logic [14:0] sit;
    logic [7:0] bt1;
    logic [7:0] bt2;
    logic [7:0] bt3;
    logic [7:0] tcon;
    logic ctrl_en;
    logic [15:0] ttc;
    logic [7:0] tec;
    logic ovr;
    logic [3:0] hp;
    logic smp_pulse;
    logic smp_bit;
    logic awready;
    logic wready;
    logic arready;
  } cgr_top_s;

  cgr_top_s s_q;
  cgr_top_s s_d;

  cgr_timing_s timing;
  logic [15:0] tim_count;
  logic tim_wrap;
  logic bt_pulse;
  logic bt_bit;

  function automatic logic [7:0] wr_byte(input logic [7:0] old, input cgr_wreq_s w);
    wr_byte = w.strb[0] ? w.data[7:0] : old;
  endfunction

  function automatic logic [3:0] lowest_set(input logic [14:0] v);
    lowest_set = `CGR_HP_NONE;
    for (int i = 14; i >= 0; i--)
      if (v[i])
        lowest_set = 4'(i);
  endfunction

  always_comb
  begin
    timing.baud_prescale = s_q.bt1[`CGR_BRP_MSB:`CGR_BRP_LSB];
    timing.resync_jump_width = s_q.bt2[`CGR_SJW_MSB:`CGR_SJW_LSB];
    timing.propagation_segment = s_q.bt2[`CGR_PRS_MSB:`CGR_PRS_LSB];
    timing.phase_segment_two = s_q.bt3[`CGR_PHS2_MSB:`CGR_PHS2_LSB];
    timing.phase_segment_one = s_q.bt3[`CGR_PHS1_MSB:`CGR_PHS1_LSB];
    timing.triple_sampling = s_q.bt3[`CGR_SMP_BIT];
  end

  cgr_bit_timer u_bit_timer
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(timing),
    .enable(s_q.ctrl_en),
    .rx_in(rx_in),
    .sample_pulse(bt_pulse),
    .sample_bit(bt_bit)
  );

  cgr_can_timer u_can_timer
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(s_q.ctrl_en),
    .prescale(s_q.tcon),
    .count(tim_count),
    .wrap(tim_wrap)
  );

  logic do_write;
  logic ovr_clear;

  always_comb
  begin
    s_d = s_q;
    ovr_clear = 1'b0;
    // Address and data may arrive in either order; hold each until paired
    if (s_axi_awvalid && !s_q.aw_full)
    begin
      s_d.aw_full = 1'b1;
      s_d.wr.addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_full)
    begin
      s_d.w_full = 1'b1;
      s_d.wr.data = s_axi_wdata;
      s_d.wr.strb = s_axi_wstrb;
    end
    do_write = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;
    if (do_write)
    begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `CGR_RESP_OKAY;
      case ({s_q.wr.addr[7:2], 2'b00})
        `CGR_OFF_IE_LO: s_d.ie[7:0] = wr_byte(s_q.ie[7:0], s_q.wr);
        // Top bit is reserved; masked so a careless write cannot set it
        `CGR_OFF_IE_HI: s_d.ie[14:8] = 7'(wr_byte({1'b0, s_q.ie[14:8]}, s_q.wr)
                                          & `CGR_IE_HI_MASK);
        `CGR_OFF_BT1: s_d.bt1 = wr_byte(s_q.bt1, s_q.wr) & `CGR_BT1_MASK;
        `CGR_OFF_BT2: s_d.bt2 = wr_byte(s_q.bt2, s_q.wr) & `CGR_BT2_MASK;
        `CGR_OFF_BT3: s_d.bt3 = wr_byte(s_q.bt3, s_q.wr) & `CGR_BT3_MASK;
        `CGR_OFF_TCON: s_d.tcon = wr_byte(s_q.tcon, s_q.wr);
        `CGR_OFF_GSTAT: ovr_clear = s_q.wr.strb[0] && s_q.wr.data[0];
        `CGR_OFF_CTRL:
          if (s_q.wr.strb[0])
            s_d.ctrl_en = s_q.wr.data[0];
        `CGR_OFF_SIT_LO, `CGR_OFF_SIT_HI, `CGR_OFF_TIM_LO, `CGR_OFF_TIM_HI,
        `CGR_OFF_TTC_LO, `CGR_OFF_TTC_HI, `CGR_OFF_TEC: ;
        default: s_d.bresp = `CGR_RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `CGR_RESP_OKAY;
      s_d.rdata = 32'h00000000;
      case ({s_axi_araddr[7:2], 2'b00})
        `CGR_OFF_IE_LO: s_d.rdata[7:0] = s_q.ie[7:0];
        `CGR_OFF_IE_HI: s_d.rdata[6:0] = s_q.ie[14:8];
        `CGR_OFF_SIT_LO: s_d.rdata[7:0] = s_q.sit[7:0];
        `CGR_OFF_SIT_HI: s_d.rdata[6:0] = s_q.sit[14:8];
        `CGR_OFF_BT1: s_d.rdata[7:0] = s_q.bt1;
        `CGR_OFF_BT2: s_d.rdata[7:0] = s_q.bt2;
        `CGR_OFF_BT3: s_d.rdata[7:0] = s_q.bt3;
        `CGR_OFF_TCON: s_d.rdata[7:0] = s_q.tcon;
        `CGR_OFF_TIM_LO: s_d.rdata[7:0] = tim_count[7:0];
        `CGR_OFF_TIM_HI: s_d.rdata[7:0] = tim_count[15:8];
        `CGR_OFF_TTC_LO: s_d.rdata[7:0] = s_q.ttc[7:0];
        `CGR_OFF_TTC_HI: s_d.rdata[7:0] = s_q.ttc[15:8];
        `CGR_OFF_TEC: s_d.rdata[7:0] = s_q.tec;
        `CGR_OFF_GSTAT: s_d.rdata[7:0] = {s_q.hp, 3'b000, s_q.ovr};
        `CGR_OFF_CTRL: s_d.rdata[0] = s_q.ctrl_en;
        default: s_d.rresp = `CGR_RESP_SLVERR;
      endcase
    end
    // Set wins over acknowledge in the same cycle
    s_d.sit = (s_q.sit & ~object_ack) | (object_event & s_q.ie);
    s_d.hp = lowest_set(s_q.sit);
    if (trigger_capture)
      s_d.ttc = tim_count;
    s_d.tec = transmit_error_count;
    s_d.ovr = (s_q.ovr && !ovr_clear) || tim_wrap;
    s_d.smp_pulse = bt_pulse;
    s_d.smp_bit = bt_bit;
    // Readies kept in flops of their own so every port leaves a register
    s_d.awready = !s_d.aw_full;
    s_d.wready = !s_d.w_full;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.hp <= `CGR_HP_NONE;
      s_q.smp_bit <= 1'b1;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign object_irq_status = s_q.sit;
  assign highest_priority_object = s_q.hp;
  assign timer_overrun_flag = s_q.ovr;
  assign sample_pulse = s_q.smp_pulse;
  assign sample_bit = s_q.smp_bit;
endmodule // cgr_top

// >>> tb/cgr_can_node.sv
// Far CAN node sending one burst of bits onto the receive line
`timescale 1ns/1ps
module cgr_can_node
#(
  parameter int BIT_CLKS = 18
)
(
  input wire logic aclk,
  input wire logic go,
  input wire logic [15:0] bits,
  output logic rx_in,
  output logic busy,
  output logic cur_bit
);
  // Idle bus is recessive, as pulled by the wired-and line
  initial
  begin
    rx_in = 1'b1;
    busy = 1'b0;
    cur_bit = 1'b1;
    forever
    begin
      @(posedge aclk);
      if (go)
      begin
        busy <= 1'b1;
        for (int i = 15; i >= 0; i--)
        begin
          rx_in <= bits[i];
          cur_bit <= bits[i];
          repeat (BIT_CLKS) @(posedge aclk);
        end
        rx_in <= 1'b1;
        cur_bit <= 1'b1;
        busy <= 1'b0;
        @(posedge aclk);
      end
    end
  end
endmodule // cgr_can_node

// >>> tb/cgr_top_assertions.sv
// Concurrent checks on the CAN general register block ports
`timescale 1ns/1ps
`include "cgr_regs.svh"
module cgr_top_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [14:0] object_event,
  input wire logic [14:0] object_ack,
  input wire logic [14:0] object_irq_status,
  input wire logic [3:0] highest_priority_object,
  input wire logic timer_overrun_flag,
  input wire logic sample_pulse,
  input wire logic sample_bit
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_bad_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h3c;
  endsequence
  sequence s_bad_answer;
    s_axi_rvalid && s_axi_rresp == `CGR_RESP_SLVERR && s_axi_rdata == 32'h0;
  endsequence
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_unmapped_read: assert property (s_bad_read |=> s_bad_answer)
    else $error("unmapped read not refused");
  a_status_cause: assert property ((object_irq_status & ~$past(object_irq_status)
    & ~$past(object_event)) == 15'h0) else $error("status set without event");
  a_ack_clears: assert property (object_ack[0] && !object_event[0]
    |=> !object_irq_status[0]) else $error("status kept after ack");
  a_none_all_ones: assert property (object_irq_status == 15'h0
    |=> highest_priority_object == `CGR_HP_NONE) else $error("empty object number wrong");
  a_lowest_first: assert property (object_irq_status[0]
    |=> highest_priority_object == 4'h0) else $error("object zero not first");
  a_overrun_sticky: assert property (timer_overrun_flag && s_axi_awready &&
    !s_axi_awvalid |=> timer_overrun_flag) else $error("overrun flag lost");
  a_sample_moves: assert property ($changed(sample_bit) |-> sample_pulse)
    else $error("bit changed off sample point");
endmodule // cgr_top_chk

bind cgr_top cgr_top_chk i_chk (.*);

// >>> tb/tb_cgr_top.sv
// Self-checking bench of the CAN general register block
`timescale 1ns/1ps
`include "cgr_regs.svh"
module tb_cgr_top;
  localparam int BT = 18;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, transmit_error_count = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, a0;
  logic [3:0] s_axi_wstrb = 4'hf, highest_priority_object;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, trigger_capture = 1'b0, go = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sample_pulse, sample_bit, timer_overrun_flag, rx_in, busy, cur, prev = 1'b0;
  logic skip = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [14:0] object_event = 15'h0, object_ack = 15'h0, object_irq_status;
  logic [15:0] pat = 16'hffff;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] offs[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h28, 8'h2c, 8'h30};
  int errors = 0, num_checks = 0, cyc = 0, gap = 0, bc = 0;
  time t1 = 0;
  always #25 aclk = ~aclk;
  cgr_top i_dut (.*);
  cgr_can_node #(.BIT_CLKS(BT)) i_node (.aclk, .go, .bits(pat), .rx_in, .busy, .cur_bit(cur));

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (!ad && s_axi_awready)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready)
      begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic ad;
    ad = 1'b0;
    if (!skip)
      rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (!ad && s_axi_arready)
      begin
        ad = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse_ev(input logic [14:0] e, input logic [14:0] k);
    @(posedge aclk);
    object_event <= e;
    object_ack <= k;
    @(posedge aclk);
    object_event <= 15'h0;
    object_ack <= 15'h0;
  endtask

  task automatic capture;
    @(posedge aclk);
    trigger_capture <= 1'b1;
    @(posedge aclk);
    trigger_capture <= 1'b0;
  endtask

  // Result watcher: oldest note against each answer seen
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      errors++;
      final_report;
    end
    if (s_axi_rvalid && s_axi_rready && !skip)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk(34'(s_axi_bresp), 34'(bq.pop_front()));
    // Skip the first cycles of a frame: the sample outputs lag the line by two register stages
    bc = busy ? bc + 1 : 0;
    gap++;
    if (bc < 5)
      prev = 1'b0;
    else if (sample_pulse)
    begin
      chk(34'(sample_bit), 34'(cur));
      if (prev)
        chk(34'(gap), 34'(BT));
      prev = 1'b1;
      gap = 0;
    end
  end

  initial
  begin
    v = $urandom(32'hbeefc77d);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i])
      rd(offs[i], 34'h0);
    for (int i = 0; i < 3; i++)
    begin
      v = $urandom & (i == 1 ? 32'h7f : 32'hff);
      a0 = v;
      wr(offs[i == 2 ? 6 : i], v, `CGR_RESP_OKAY);
      rd(offs[i == 2 ? 6 : i], {2'b00, a0});
    end
    wr(8'h3c, 32'hff, `CGR_RESP_SLVERR);
    rd(8'h3c, {`CGR_RESP_SLVERR, 32'h0});
    wr(`CGR_OFF_IE_LO, 32'h0d, `CGR_RESP_OKAY);
    wr(`CGR_OFF_IE_HI, 32'h40, `CGR_RESP_OKAY);
    pulse_ev(15'h401d, 15'h0);
    rd(`CGR_OFF_SIT_LO, 34'h0d);
    rd(`CGR_OFF_SIT_HI, 34'h40);
    pulse_ev(15'h0, 15'h0004);
    rd(`CGR_OFF_SIT_LO, 34'h09);
    pulse_ev(15'h0, 15'h4009);
    rd(`CGR_OFF_SIT_HI, 34'h0);
    v = $urandom;
    transmit_error_count <= v[7:0];
    rd(`CGR_OFF_TEC, {26'h0, v[7:0]});
    rd(`CGR_OFF_GSTAT, 34'hf0);
    chk(34'(timer_overrun_flag), 34'h0);
    wr(`CGR_OFF_CTRL, 32'h0, `CGR_RESP_OKAY);
    capture();
    rd(`CGR_OFF_TTC_LO, 34'h0);
    rd(`CGR_OFF_TIM_HI, 34'h0);
    wr(`CGR_OFF_TCON, 32'h01, `CGR_RESP_OKAY);
    wr(`CGR_OFF_CTRL, 32'h01, `CGR_RESP_OKAY);
    rd(`CGR_OFF_CTRL, 34'h1);
    capture();
    t1 = $time;
    skip = 1'b1;
    rd(`CGR_OFF_TTC_LO, 34'h0);
    a0 = v;
    // Second capture strobe lands exactly 160 clocks after the first
    while ($time - t1 < 158 * 50)
      @(posedge aclk);
    capture();
    rd(`CGR_OFF_TTC_LO, 34'h0);
    // Tick every 8*(1+1) clocks, so 160 clocks give 10 counts
    chk(34'(v[7:0] - a0[7:0]), 34'ha);
    wr(`CGR_OFF_BT1, 32'h02, `CGR_RESP_OKAY);
    // Cleared only once the last skipped answer has passed the watcher
    skip = 1'b0;
    wr(`CGR_OFF_BT2, 32'h02, `CGR_RESP_OKAY);
    for (int s = 0; s < 2; s++)
    begin
      wr(`CGR_OFF_BT3, 32'h24 | s, `CGR_RESP_OKAY);
      rd(`CGR_OFF_BT3, 34'h24 | s);
      pat <= {1'b0, 15'($urandom)};
      // Align the frame so each falling edge opens propagation and needs no resync
      while (!sample_pulse)
        @(posedge aclk);
      repeat (5) @(posedge aclk);
      go <= 1'b1;
      while (!busy)
        @(posedge aclk);
      go <= 1'b0;
      while (busy)
        @(posedge aclk);
    end
    final_report;
  end
endmodule // tb_cgr_top
